// File: design/wake_wd_pkg.sv
// Package: constants for the wake/watchdog/reset sequencer.
// Assumes a single 100 MHz system clock; no registers reachable by software.
package wake_wd_pkg;
   // ***************************************************************
   // Clock and timebase
   // ***************************************************************
   localparam int CLK_MHZ = 100;
   localparam int TICK_NS = 1000;
   localparam int TICK_DIV = TICK_NS * CLK_MHZ / 1000;
   localparam int DIV_W = 8;

   // ***************************************************************
   // Interval lengths in timebase ticks, ratio 8:1:4
   // ***************************************************************
   localparam int ALERT_PERIOD_US = 40000;
   localparam int RST_DELAY_US = 5000;
   localparam int RST_TO_ALERT_US = 20000;
   localparam int UNIT_US = 5000;
   localparam int PERIOD_UNITS = ALERT_PERIOD_US / UNIT_US;
   localparam int RDLY_UNITS = RST_DELAY_US / UNIT_US;
   localparam int R2A_UNITS = RST_TO_ALERT_US / UNIT_US;
   localparam int CNT_W = 20;

   // ***************************************************************
   // Response time bound
   // ***************************************************************
   localparam int RESP_MAX_NS = 10000;
   localparam int RESP_MAX_CYC = RESP_MAX_NS * CLK_MHZ / 1000;

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_FIRST,
      ST_HIGH,
      ST_LOW
   } seq_state_t;
endpackage

// File: design/tick_gen.sv
// Timebase divider: one-cycle tick every DIV clocks.
// Assumes the system clock and active-low asynchronous reset.
`timescale 1ns/100ps
module tick_gen #(
   parameter int DIV = wake_wd_pkg::TICK_DIV
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   output logic tick_out
);
   logic [wake_wd_pkg::DIV_W-1:0] cnt_r;
   logic [wake_wd_pkg::DIV_W-1:0] cnt_nxt;
   wire last_w = (cnt_r == wake_wd_pkg::DIV_W'(DIV - 1));

   assign cnt_nxt = last_w ? '0 : cnt_r + 8'h01;

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_r <= '0;
         tick_out <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_out <= last_w;
      end
   end
endmodule

// File: design/wake_watchdog_reset_sequencer.sv
// Wake alert, watchdog monitor and reset sequencer for a host processor.
// Assumes watchdog_in and the undervoltage comparator are synchronous to sys_clk_in.
//
// Contract
// - Alert is a continuous roughly 50% square wave while reset is inactive.
// - Alert period is nominally 40 ms, within 30 to 50 ms.
// - First watchdog falling edge drops alert within 10 us until next cycle.
// - Further watchdog pulses in the same cycle are ignored.
// - Missing watchdog falling edge in a period asserts reset low.
// - Reset held low at power up until output is in regulation.
// - Reset low while output is under the low threshold, with hysteresis.
// - Reset released after nominal 5 ms delay once cause clears.
// - First alert rise comes nominally 20 ms after reset rises.
// - Reset falling drops alert within 10 us.
// - All intervals come from one common timebase.
// - Alert low for any reset; alert cycle restarts after reset.
// - Missed-watchdog reset pulse issued at end of that alert cycle.
// - Period, reset delay and reset-to-alert delay scale 8 to 1 to 4.
`timescale 1ns/100ps
module wake_watchdog_reset_sequencer #(
   parameter int TICK_DIV = wake_wd_pkg::TICK_DIV,
   parameter int UNIT_TICKS = wake_wd_pkg::UNIT_US
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic watchdog_in,
   input wire logic undervolt_in,
   output logic host_alert_out,
   output logic host_rstn_out
);
   // ***************************************************************
   // Timebase
   // ***************************************************************
   logic tick_w;
   tick_gen #(.DIV(TICK_DIV)) u_tick (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .tick_out(tick_w)
   );

   localparam logic [wake_wd_pkg::CNT_W-1:0] PERIOD_T =
      wake_wd_pkg::CNT_W'(wake_wd_pkg::PERIOD_UNITS * UNIT_TICKS);
   localparam logic [wake_wd_pkg::CNT_W-1:0] HALF_T = PERIOD_T >> 1;
   localparam logic [wake_wd_pkg::CNT_W-1:0] RDLY_T =
      wake_wd_pkg::CNT_W'(wake_wd_pkg::RDLY_UNITS * UNIT_TICKS);
   localparam logic [wake_wd_pkg::CNT_W-1:0] R2A_T =
      wake_wd_pkg::CNT_W'(wake_wd_pkg::R2A_UNITS * UNIT_TICKS);

   // ***************************************************************
   // Input capture
   // ***************************************************************
   // Inputs are already synchronous; one stage gives the edge detector a history
   logic wd_d_r;
   logic uv_r;
   wire wd_fall_w = wd_d_r & ~watchdog_in;

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wd_d_r <= 1'b1;
         uv_r <= 1'b1;
      end else begin
         wd_d_r <= watchdog_in;
         uv_r <= undervolt_in;
      end
   end

   // ***************************************************************
   // Reset sequencer
   // ***************************************************************
   // Comparator hysteresis lives in the analog block; here we only see its level
   logic [wake_wd_pkg::CNT_W-1:0] rcnt_r;
   logic [wake_wd_pkg::CNT_W-1:0] rcnt_nxt;
   logic rst_r;
   logic rst_nxt;
   logic miss_w;
   wire cause_w = uv_r | miss_w;
   wire rdone_w = tick_w & (rcnt_r == RDLY_T - 20'h00001);

   always_comb begin
      rcnt_nxt = rcnt_r;
      rst_nxt = rst_r;
      if (cause_w) begin
         rst_nxt = 1'b1;
         rcnt_nxt = '0;
      end else if (rst_r) begin
         if (rdone_w) begin
            rst_nxt = 1'b0;
            rcnt_nxt = '0;
         end else if (tick_w) begin
            rcnt_nxt = rcnt_r + 20'h00001;
         end
      end
   end

   // ***************************************************************
   // Alert sequencer
   // ***************************************************************
   wake_wd_pkg::seq_state_t st_r;
   wake_wd_pkg::seq_state_t st_nxt;
   logic [wake_wd_pkg::CNT_W-1:0] acnt_r;
   logic [wake_wd_pkg::CNT_W-1:0] acnt_nxt;
   logic seen_r;
   logic seen_nxt;
   logic alert_nxt;
   wire a_last_w = tick_w & (acnt_r == PERIOD_T - 20'h00001);
   wire a_half_w = tick_w & (acnt_r == HALF_T - 20'h00001);
   wire f_last_w = tick_w & (acnt_r == R2A_T - 20'h00001);

   // Missed edge judged only at the end of the cycle
   assign miss_w = (st_r == wake_wd_pkg::ST_LOW) & a_last_w & ~seen_r
      & ~wd_fall_w;

   always_comb begin
      st_nxt = st_r;
      acnt_nxt = tick_w ? acnt_r + 20'h00001 : acnt_r;
      seen_nxt = seen_r | wd_fall_w;
      alert_nxt = host_alert_out;
      case (st_r)
         wake_wd_pkg::ST_HOLD: begin
            alert_nxt = 1'b0;
            acnt_nxt = '0;
            seen_nxt = 1'b0;
            if (!rst_r) begin
               st_nxt = wake_wd_pkg::ST_FIRST;
            end
         end
         wake_wd_pkg::ST_FIRST: begin
            alert_nxt = 1'b0;
            seen_nxt = 1'b0;
            if (f_last_w) begin
               st_nxt = wake_wd_pkg::ST_HIGH;
               alert_nxt = 1'b1;
               acnt_nxt = '0;
            end
         end
         wake_wd_pkg::ST_HIGH: begin
            if (wd_fall_w && !seen_r) begin
               alert_nxt = 1'b0;
            end
            if (a_half_w) begin
               st_nxt = wake_wd_pkg::ST_LOW;
               alert_nxt = 1'b0;
            end
         end
         wake_wd_pkg::ST_LOW: begin
            alert_nxt = 1'b0;
            if (a_last_w) begin
               st_nxt = wake_wd_pkg::ST_HIGH;
               alert_nxt = 1'b1;
               acnt_nxt = '0;
               seen_nxt = 1'b0;
            end
         end
         default: begin
            st_nxt = wake_wd_pkg::ST_HOLD;
         end
      endcase
      if (cause_w || rst_r) begin
         st_nxt = wake_wd_pkg::ST_HOLD;
         alert_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_r <= 1'b1;
         rcnt_r <= '0;
         host_rstn_out <= 1'b0;
      end else begin
         rst_r <= rst_nxt;
         rcnt_r <= rcnt_nxt;
         host_rstn_out <= ~rst_nxt;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r <= wake_wd_pkg::ST_HOLD;
         acnt_r <= '0;
         seen_r <= 1'b0;
         host_alert_out <= 1'b0;
      end else begin
         st_r <= st_nxt;
         acnt_r <= acnt_nxt;
         seen_r <= seen_nxt;
         host_alert_out <= alert_nxt;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   localparam int RESP_CYC = wake_wd_pkg::RESP_MAX_CYC;

   // Tick counts kept apart from the sequencer counters, so a wrong compare
   // value there shows up as a wrong interval here
   // They wrap on long runs; each is only read at fixed intervals after the event that clears it
   logic [wake_wd_pkg::CNT_W-1:0] since_rise_r;
   logic [wake_wd_pkg::CNT_W-1:0] since_rel_r;
   logic [wake_wd_pkg::CNT_W-1:0] quiet_r;
   logic alert_d_r;
   logic rstn_d_r;
   wire alert_rise_w = host_alert_out & ~alert_d_r;
   wire rstn_rise_w = host_rstn_out & ~rstn_d_r;
   wire [wake_wd_pkg::CNT_W-1:0] tick_inc_w = wake_wd_pkg::CNT_W'(tick_w);

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         alert_d_r <= 1'b0;
         rstn_d_r <= 1'b0;
         since_rise_r <= '0;
         since_rel_r <= '0;
         quiet_r <= '0;
      end else begin
         alert_d_r <= host_alert_out;
         rstn_d_r <= host_rstn_out;
         since_rise_r <= alert_rise_w ? '0 : since_rise_r + tick_inc_w;
         since_rel_r <= rstn_rise_w ? '0 : since_rel_r + tick_inc_w;
         quiet_r <= cause_w ? '0 : quiet_r + tick_inc_w;
      end
   end

   property p_alert_low_in_reset;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      !host_rstn_out |-> !host_alert_out;
   endproperty
   a_alert_low_in_reset: assert property (p_alert_low_in_reset)
      else $error("alert high during reset");

   property p_wd_drops_alert;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (host_alert_out && wd_fall_w && !seen_r && host_rstn_out && !cause_w)
      |=> !host_alert_out;
   endproperty
   a_wd_drops_alert: assert property (p_wd_drops_alert)
      else $error("alert not dropped by watchdog edge");

   property p_rst_drops_alert;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $fell(host_rstn_out) |-> ##[0:1] !host_alert_out;
   endproperty
   a_rst_drops_alert: assert property (p_rst_drops_alert)
      else $error("alert not dropped by reset");

   property p_uv_resets;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      uv_r |=> !host_rstn_out;
   endproperty
   a_uv_resets: assert property (p_uv_resets)
      else $error("reset not asserted on undervoltage");

   property p_miss_resets;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      miss_w |=> !host_rstn_out ##1 !host_rstn_out;
   endproperty
   a_miss_resets: assert property (p_miss_resets)
      else $error("missed watchdog gave no reset");

   property p_release_after_delay;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(host_rstn_out) |-> quiet_r == RDLY_T && !$past(uv_r);
   endproperty
   a_release_after_delay: assert property (p_release_after_delay)
      else $error("reset released without delay");

   property p_ignore_second;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (seen_r && st_r == wake_wd_pkg::ST_HIGH && !a_half_w && !cause_w)
      |=> $stable(host_alert_out);
   endproperty
   a_ignore_second: assert property (p_ignore_second)
      else $error("alert changed by a later watchdog pulse");

   property p_first_rise;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(host_alert_out) && $past(st_r) != wake_wd_pkg::ST_LOW
      |-> $past(st_r) == wake_wd_pkg::ST_FIRST && since_rel_r == R2A_T;
   endproperty
   a_first_rise: assert property (p_first_rise)
      else $error("first alert rise at wrong delay after reset");

   property p_period;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(host_alert_out) && $past(st_r) == wake_wd_pkg::ST_LOW
      |-> since_rise_r == PERIOD_T;
   endproperty
   a_period: assert property (p_period)
      else $error("alert period has wrong length");

   property p_half_high;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      $past(st_r) == wake_wd_pkg::ST_HIGH && st_r == wake_wd_pkg::ST_LOW
      |-> since_rise_r == HALF_T;
   endproperty
   a_half_high: assert property (p_half_high)
      else $error("alert high half has wrong length");

   property p_wd_resp;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (host_alert_out && wd_fall_w && !seen_r && !rst_r && !cause_w)
      |-> ##[1:RESP_CYC] !host_alert_out;
   endproperty
   a_wd_resp: assert property (p_wd_resp)
      else $error("alert not dropped within the response bound");
endmodule

// File: dv/host_model.sv
// Host processor model: answers each alert rising edge with watchdog pulses.
// Assumes the bench sets the pulse count no later than two clocks after the alert rises.
`timescale 1ns/100ps
module host_model (
   input wire logic sys_clk_in,
   input wire logic host_alert_in,
   input wire logic [1:0] pulses_in,
   output logic wd_out
);
   // ***************************************************************
   // Pulse generator
   // ***************************************************************
   // Each phase lasts 10 clocks, the shortest the device must accept
   localparam int PHASE = 10;
   logic alert_d;

   initial begin
      wd_out = 1'b1;
      alert_d = 1'b0;
      forever begin
         @(negedge sys_clk_in);
         if (host_alert_in === 1'b1 && alert_d === 1'b0) begin
            repeat (2) @(negedge sys_clk_in);
            // Nonblocking so the bench never races the pin at the same edge
            for (int i = 0; i < int'(pulses_in); i++) begin
               wd_out <= 1'b0;
               repeat (PHASE) @(negedge sys_clk_in);
               wd_out <= 1'b1;
               repeat (PHASE) @(negedge sys_clk_in);
            end
         end
         alert_d = host_alert_in;
      end
   end
endmodule

// File: dv/tb.sv
// Testbench for the wake alert, watchdog and reset sequencer.
// Assumes a shortened timebase: 2 clocks per tick, 4 ticks per unit.
`timescale 1ns/100ps
module tb;
   // ***************************************************************
   // Setup
   // ***************************************************************
   localparam int DIV = 2;
   localparam int UT = 4;
   localparam int U = DIV * UT;
   typedef struct {logic [1:0] p; int per; logic rst;} row_t;
   row_t rows [3] = '{'{2'h1, 8 * U, 1'b1}, '{2'h2, 8 * U, 1'b1}, '{2'h3, 8 * U, 1'b1}};
   logic sys_clk_in, rstn_in, undervolt_in, host_alert_out, host_rstn_out;
   wire logic watchdog_in;
   logic [1:0] pulses;
   int mismatches, comparisons, n, cyc, t0;

   wake_watchdog_reset_sequencer #(.TICK_DIV(DIV), .UNIT_TICKS(UT))
      wake_watchdog_reset_sequencer_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .watchdog_in(watchdog_in), .undervolt_in(undervolt_in),
      .host_alert_out(host_alert_out), .host_rstn_out(host_rstn_out));
   host_model host_model_inst (.sys_clk_in(sys_clk_in), .host_alert_in(host_alert_out),
      .pulses_in(pulses), .wd_out(watchdog_in));

   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   always @(negedge sys_clk_in) cyc <= cyc + 1;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   task conclude;
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task chk_rng(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
      end
   endtask

   // Counts falling edges until the chosen signal shows the level; bounded
   task wait_for(input int sel, input logic v, input int lim, output int cnt);
      logic s;
      cnt = 0;
      s = (sel == 0) ? host_alert_out : (sel == 1) ? host_rstn_out : watchdog_in;
      while (s !== v) begin
         if (cnt >= lim) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, s, v);
            conclude();
         end
         @(negedge sys_clk_in);
         cnt++;
         s = (sel == 0) ? host_alert_out : (sel == 1) ? host_rstn_out : watchdog_in;
      end
   endtask

   // ***************************************************************
   // Sequence
   // ***************************************************************
   initial begin
      rstn_in = 1'b0;
      undervolt_in = 1'b0;
      pulses = 2'h1;
      mismatches = 0;
      comparisons = 0;
      cyc = 0;
      repeat (20) @(negedge sys_clk_in);
      chk_bit(host_rstn_out, 1'b0);
      chk_bit(host_alert_out, 1'b0);
      rstn_in = 1'b1;
      wait_for(1, 1'b1, 40, n);
      chk_rng(n, U - 3, U + 4);
      wait_for(0, 1'b1, 60, n);
      chk_rng(n, 4 * U - 3, 4 * U + 3);
      // Host answers with one, two and three pulses per cycle
      foreach (rows[i]) begin
         pulses = rows[i].p;
         wait_for(0, 1'b1, 80, n);
         t0 = cyc;
         wait_for(2, 1'b0, 10, n);
         wait_for(0, 1'b0, 20, n);
         // Host drops watchdog two clocks after the rise; the fall follows at the next edge
         chk_rng(cyc - t0, 3, 2 + wake_wd_pkg::RESP_MAX_CYC);
         wait_for(0, 1'b1, 80, n);
         chk_rng(cyc - t0, rows[i].per - 2, rows[i].per + 2);
         chk_bit(host_rstn_out, rows[i].rst);
      end
      // Silent host: full half-high cycle, then a reset at cycle end
      pulses = 2'h0;
      wait_for(0, 1'b1, 80, n);
      wait_for(0, 1'b0, 40, n);
      chk_rng(n, 4 * U - 2, 4 * U + 2);
      wait_for(1, 1'b0, 40, n);
      chk_rng(n, 4 * U - 2, 4 * U + 2);
      chk_bit(host_alert_out, 1'b0);
      wait_for(1, 1'b1, 20, n);
      chk_rng(n, U - 2, U + 2);
      pulses = 2'h1;
      wait_for(0, 1'b1, 60, n);
      chk_rng(n, 4 * U - 3, 4 * U + 3);
      // Undervoltage while the alert is high
      undervolt_in = 1'b1;
      wait_for(1, 1'b0, 4, n);
      chk_rng(n, 1, 3);
      chk_bit(host_alert_out, 1'b0);
      repeat (30) @(negedge sys_clk_in);
      chk_bit(host_rstn_out, 1'b0);
      undervolt_in = 1'b0;
      wait_for(1, 1'b1, 20, n);
      chk_rng(n, U - 3, U + 4);
      wait_for(0, 1'b1, 60, n);
      chk_rng(n, 4 * U - 3, 4 * U + 3);
      conclude();
   end
endmodule
